/* File: src/slp_map.vh */
// slp_map.vh: register offsets, field positions, reset values and timing
// counts for the sleep-mode clock controller.
// assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef SLP_MAP_VH
`define SLP_MAP_VH

// register byte offsets
`define SLP_CTRL_OFS 4'h0
`define SLP_STAT_OFS 4'h4
`define SLP_RESP_OK 2'b00
`define SLP_RESP_ERR 2'b10

// control register fields
`define SLP_CTRL_MODE_LO 0
`define SLP_CTRL_MODE_HI 2
`define SLP_CTRL_T2ASY 3
`define SLP_CTRL_ADCEN 4
`define SLP_CTRL_CMPEN 5
`define SLP_CTRL_CMPREF 6
`define SLP_CTRL_INT0LVL 7
`define SLP_CTRL_INT1LVL 8
`define SLP_CTRL_W 9
`define SLP_CTRL_RST 9'h000

// sleep mode encodings
`define SLP_MODE_IDLE 3'h0
`define SLP_MODE_NOISE 3'h1
`define SLP_MODE_PDOWN 3'h2
`define SLP_MODE_PSAVE 3'h3
`define SLP_MODE_STBY 3'h6

// timing
`define SLP_CLK_MHZ 20
`define SLP_STBY_WAKE_CYC 6
`define SLP_PD_WAKE_CYC 16
`define SLP_VREF_START_US 40
`define SLP_VREF_START_CYC (`SLP_VREF_START_US * `SLP_CLK_MHZ)
`define SLP_TMR_W 12

`endif

/* File: src/slp_cycle_timer.v */
// slp_cycle_timer: loadable down-counter with a done flag.
// assumes load values fit in the counter width.
`timescale 1ns/100ps
`include "slp_map.vh"

module slp_cycle_timer (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // control
   input wire load_i,
   input wire [`SLP_TMR_W-1:0] value_i,
   // status
   output wire done_o
);

   reg [`SLP_TMR_W-1:0] cnt_r;

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r <= {`SLP_TMR_W{1'b0}};
      end else if (load_i) begin
         cnt_r <= value_i;
      end else if (cnt_r != {`SLP_TMR_W{1'b0}}) begin
         cnt_r <= cnt_r - {{(`SLP_TMR_W-1){1'b0}}, 1'b1};
      end
   end

   assign done_o = (cnt_r == {`SLP_TMR_W{1'b0}}) && !load_i;

endmodule // slp_cycle_timer

/* File: src/slp_ctrl.v */
// slp_ctrl: sleep-mode controller deciding clock domains, oscillators,
// wake sources and helper power enables; AXI4-Lite register slave.
// assumes all inputs synchronous to clk_i; clock enables feed glitch-free
// gates outside this block.
`timescale 1ns/100ps
`include "slp_map.vh"

// Operation
// RULE1 - mode field 000 idle, 001 noise reduction, 010 power-down, 011 save
// RULE2 - field 110 with crystal clock option enters standby
// RULE3 - standby equals power-down but main oscillator keeps running
// RULE4 - standby wakes back to normal operation after 6 clock cycles
// RULE5 - idle stops core and program-memory clocks only; any interrupt wakes; without async select code also stops async clocks and ignores timer2
// RULE6 - noise reduction stops io, core, program-memory clocks; converter runs
// RULE7 - power-down stops oscillator and all clocks; async wake logic only
// RULE8 - async timer clock, oscillator, timer wake need async select bit
// RULE9 - in deeper modes external lines wake only when level-sensitive
// RULE10 - converter stays enabled in every sleep mode when enabled
// RULE11 - converter re-enable makes next conversion an extended one
// RULE12 - software should switch converter off before sleeping
// RULE13 - comparator is disabled automatically beyond idle and noise modes
// RULE14 - software should disable comparator before idle or noise modes
// RULE15 - comparator using internal reference keeps reference on in sleep
// RULE16 - brown-out detector stays enabled in sleep when fuse enables it
// RULE17 - enabled watchdog keeps running in every sleep mode
// RULE18 - reference on when detector, comparator or converter needs it
// RULE19 - software waits reference start-up time after re-enabling it
// RULE20 - reference kept on through sleep is usable at once after wake
// RULE21 - port input buffers off when io and converter clocks both stop
// RULE22 - pin input logic stays on when needed to detect wake-up
// RULE23 - mode latched at entry instruction; allowed wake restores clocks
// RULE24 - standby code without crystal is ignored; clocks keep running
module slp_ctrl #(
   parameter PD_WAKE_CYC = `SLP_PD_WAKE_CYC
) (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // axi4-lite slave
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // core and configuration
   input wire sleep_instr_i,
   input wire xtal_clk_option_i,
   input wire brownout_enable_fuse_i,
   input wire wdt_enable_i,
   // wake sources
   input wire ext_irq_line_0_i,
   input wire ext_irq_line_1_i,
   input wire ext_irq_req_0_i,
   input wire ext_irq_req_1_i,
   input wire two_wire_iface_match_i,
   input wire timer2_irq_i,
   input wire self_program_op_rdy_i,
   input wire adc_done_irq_i,
   input wire other_io_irq_i,
   input wire adc_conv_start_i,
   // clock domain and oscillator enables
   output reg core_clock_domain_en_o,
   output reg program_memory_clock_domain_en_o,
   output reg peripheral_io_clock_domain_en_o,
   output reg converter_clock_domain_en_o,
   output reg async_timer_clock_domain_en_o,
   output reg main_osc_en_o,
   output reg timer_osc_en_o,
   // helper module enables
   output reg adc_en_o,
   output reg adc_ext_conv_o,
   output reg comp_en_o,
   output reg vref_en_o,
   output wire vref_ready_o,
   output reg bod_en_o,
   output reg wdt_en_o,
   output reg input_buf_en_o,
   output reg [2:0] wake_pin_buf_en_o,
   // status
   output reg sleeping_o
);

   localparam [2:0] ST_ACT = 3'b001;
   localparam [2:0] ST_SLP = 3'b010;
   localparam [2:0] ST_WAK = 3'b100;

   function is_deep;
      input [2:0] m;
      begin
         is_deep = (m == `SLP_MODE_PDOWN) || (m == `SLP_MODE_PSAVE) ||
                   (m == `SLP_MODE_STBY);
      end
   endfunction

   function mode_ok;
      input [2:0] m;
      input xtal;
      begin
         mode_ok = (m == `SLP_MODE_IDLE) || (m == `SLP_MODE_NOISE) ||
                   (m == `SLP_MODE_PDOWN) || (m == `SLP_MODE_PSAVE) ||
                   ((m == `SLP_MODE_STBY) && xtal);
      end
   endfunction

   reg [`SLP_CTRL_W-1:0] ctrl_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [2:0] mode_r;
   reg adc_en_d_r;
   reg vref_need_d_r;
   reg wake_load;
   reg [`SLP_TMR_W-1:0] wake_val;
   reg wake_ev;
   reg [6:0] clk_nxt;
   wire [2:0] sel_mode = ctrl_r[`SLP_CTRL_MODE_HI:`SLP_CTRL_MODE_LO];
   wire t2asy = ctrl_r[`SLP_CTRL_T2ASY];
   wire lvl0 = ctrl_r[`SLP_CTRL_INT0LVL];
   wire lvl1 = ctrl_r[`SLP_CTRL_INT1LVL];
   wire asleep = (state_nxt != ST_ACT);
   wire wake_done;
   wire vref_done;
   wire lvl_wake = (lvl0 && !ext_irq_line_0_i) ||
                   (lvl1 && !ext_irq_line_1_i);
   wire vref_need = brownout_enable_fuse_i || ctrl_r[`SLP_CTRL_ADCEN] ||
                    (ctrl_r[`SLP_CTRL_CMPEN] && ctrl_r[`SLP_CTRL_CMPREF]);
   wire wr_go;
   wire rd_go;
   // latched mode once asleep, so the entry cycle already gets its own table
   wire [2:0] clk_mode = (state_r == ST_ACT) ? sel_mode : mode_r;
   // counter loads are cut to the timer width on purpose
   localparam integer STBY_M1 = `SLP_STBY_WAKE_CYC - 1;
   localparam integer PD_M1 = PD_WAKE_CYC - 1;
   localparam integer VREF_CYC = `SLP_VREF_START_CYC;
   localparam [`SLP_CTRL_W-1:0] CTRL_RST = `SLP_CTRL_RST;

   // allowed wake sources per latched mode
   always @* begin
      case (mode_r)
         `SLP_MODE_IDLE: begin
            wake_ev = ext_irq_req_0_i || ext_irq_req_1_i || lvl_wake ||
                      two_wire_iface_match_i || (timer2_irq_i && t2asy) ||
                      self_program_op_rdy_i || adc_done_irq_i ||
                      other_io_irq_i; // [RULE5] [RULE8]
         end
         `SLP_MODE_NOISE: begin
            wake_ev = lvl_wake || two_wire_iface_match_i ||
                      (timer2_irq_i && t2asy) || self_program_op_rdy_i ||
                      adc_done_irq_i; // [RULE9] [RULE8]
         end
         `SLP_MODE_PSAVE: begin
            wake_ev = lvl_wake || two_wire_iface_match_i ||
                      (timer2_irq_i && t2asy); // [RULE8] [RULE9]
         end
         default: begin
            wake_ev = lvl_wake || two_wire_iface_match_i; // [RULE7] [RULE9]
         end
      endcase
   end

   // sleep sequencer
   always @* begin
      state_nxt = state_r;
      wake_load = 1'b0;
      wake_val = {`SLP_TMR_W{1'b0}};
      case (state_r)
         ST_ACT: begin
            if (sleep_instr_i && mode_ok(sel_mode, xtal_clk_option_i)) begin
               state_nxt = ST_SLP; // [RULE2] [RULE23] [RULE24]
            end
         end
         ST_SLP: begin
            if (wake_ev) begin
               if (is_deep(mode_r)) begin
                  // a stopped oscillator needs time to settle first
                  state_nxt = ST_WAK;
                  wake_load = 1'b1;
                  if (mode_r == `SLP_MODE_STBY) begin
                     wake_val = STBY_M1[`SLP_TMR_W-1:0]; // [RULE4]
                  end else begin
                     wake_val = PD_M1[`SLP_TMR_W-1:0];
                  end
               end else begin
                  state_nxt = ST_ACT; // [RULE23]
               end
            end
         end
         ST_WAK: begin
            if (wake_done) begin
               state_nxt = ST_ACT; // [RULE4] [RULE23]
            end
         end
         default: begin
            state_nxt = ST_ACT;
         end
      endcase
   end

   // clock domains {core, flash, io, adc, async, main osc, timer osc}
   always @* begin
      if (!asleep) begin
         clk_nxt = 7'h7f;
      end else begin
         case (clk_mode)
            `SLP_MODE_IDLE: clk_nxt = {4'b0011, t2asy, 1'b1, t2asy};
            `SLP_MODE_NOISE: clk_nxt = {4'b0001, t2asy, 1'b1, t2asy};
            `SLP_MODE_PSAVE: clk_nxt = {4'b0000, t2asy, 1'b0, t2asy};
            `SLP_MODE_STBY: clk_nxt = 7'h02;
            default: clk_nxt = 7'h00;
         endcase
      end
   end

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= ST_ACT;
         mode_r <= `SLP_MODE_IDLE;
         core_clock_domain_en_o <= 1'b1;
         program_memory_clock_domain_en_o <= 1'b1;
         peripheral_io_clock_domain_en_o <= 1'b1;
         converter_clock_domain_en_o <= 1'b1;
         async_timer_clock_domain_en_o <= 1'b1;
         main_osc_en_o <= 1'b1;
         timer_osc_en_o <= 1'b1;
         sleeping_o <= 1'b0;
         input_buf_en_o <= 1'b1;
         wake_pin_buf_en_o <= 3'h7;
         comp_en_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_ACT && state_nxt == ST_SLP) begin
            mode_r <= sel_mode; // [RULE23]
         end
         // [RULE1] [RULE3] [RULE5] [RULE6] [RULE7] [RULE8]
         {core_clock_domain_en_o, program_memory_clock_domain_en_o,
          peripheral_io_clock_domain_en_o, converter_clock_domain_en_o,
          async_timer_clock_domain_en_o, main_osc_en_o,
          timer_osc_en_o} <= clk_nxt;
         sleeping_o <= asleep;
         input_buf_en_o <= clk_nxt[4] | clk_nxt[3]; // [RULE21]
         // two-wire pins always keep their inputs for wake-up; ext_irq_line_0 and ext_irq_line_1 only when level-sensitive or io/adc clocks run
         wake_pin_buf_en_o <= {1'b1, lvl1 | clk_nxt[4] | clk_nxt[3],
                               lvl0 | clk_nxt[4] | clk_nxt[3]}; // [RULE22]
         comp_en_o <= ctrl_r[`SLP_CTRL_CMPEN] &&
                      !(asleep && is_deep(clk_mode)); // [RULE13]
      end
   end

   // helper power enables and converter tracking
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         adc_en_o <= 1'b0;
         adc_en_d_r <= 1'b0;
         adc_ext_conv_o <= 1'b0;
         vref_en_o <= 1'b0;
         vref_need_d_r <= 1'b0;
         bod_en_o <= 1'b0;
         wdt_en_o <= 1'b0;
      end else begin
         adc_en_o <= ctrl_r[`SLP_CTRL_ADCEN]; // [RULE10]
         adc_en_d_r <= ctrl_r[`SLP_CTRL_ADCEN];
         // a re-enable in the clearing cycle still marks extended
         if (ctrl_r[`SLP_CTRL_ADCEN] && !adc_en_d_r) begin
            adc_ext_conv_o <= 1'b1; // [RULE11]
         end else if (adc_conv_start_i) begin
            adc_ext_conv_o <= 1'b0;
         end
         vref_en_o <= vref_need; // [RULE15] [RULE18]
         vref_need_d_r <= vref_need;
         bod_en_o <= brownout_enable_fuse_i; // [RULE16]
         wdt_en_o <= wdt_enable_i; // [RULE17]
      end
   end

   slp_cycle_timer u_wake_tmr (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(wake_load),
      .value_i(wake_val),
      .done_o(wake_done)
   );

   // start-up only restarts on a fresh enable, so sleep does not cost it
   slp_cycle_timer u_vref_tmr (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(vref_need && !vref_need_d_r),
      .value_i(VREF_CYC[`SLP_TMR_W-1:0]),
      .done_o(vref_done)
   );

   assign vref_ready_o = vref_en_o && vref_done; // [RULE19] [RULE20]

   // register bus: write taken when address and data are both offered
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_go;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
         localparam HI = (gi == 0) ? 7 : `SLP_CTRL_W - 1;
         always @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               ctrl_r[HI:gi*8] <= CTRL_RST[HI:gi*8];
            end else if (wr_go && s_axi_wstrb[gi] &&
                         s_axi_awaddr[3:2] == `SLP_CTRL_OFS >> 2) begin
               ctrl_r[HI:gi*8] <= s_axi_wdata[HI:gi*8];
            end
         end
      end
   endgenerate

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SLP_RESP_OK;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `SLP_RESP_OK;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr[3:2] == `SLP_CTRL_OFS >> 2 ||
                            s_axi_awaddr[3:2] == `SLP_STAT_OFS >> 2) ?
                           `SLP_RESP_OK : `SLP_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SLP_RESP_OK;
            if (s_axi_araddr[3:2] == `SLP_CTRL_OFS >> 2) begin
               s_axi_rdata <= {23'h00_0000, ctrl_r};
            end else if (s_axi_araddr[3:2] == `SLP_STAT_OFS >> 2) begin
               s_axi_rdata <= {17'h0_0000, adc_ext_conv_o, vref_ready_o,
                  core_clock_domain_en_o, program_memory_clock_domain_en_o,
                  peripheral_io_clock_domain_en_o,
                  converter_clock_domain_en_o,
                  async_timer_clock_domain_en_o, main_osc_en_o,
                  timer_osc_en_o, mode_r, state_r};
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `SLP_RESP_ERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // slp_ctrl

/* File: sim/slp_ctrl_checker.sv */
// slp_ctrl_checker: port-level checks on the sleep-mode clock controller.
// assumes it is bound to slp_ctrl and sees its ports only.
`timescale 1ns/100ps
module slp_ctrl_checker (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // observed inputs
   input wire sleep_instr_i,
   input wire brownout_enable_fuse_i,
   input wire wdt_enable_i,
   input wire two_wire_iface_match_i,
   input wire other_io_irq_i,
   // observed outputs
   input wire core_clock_domain_en_o,
   input wire program_memory_clock_domain_en_o,
   input wire peripheral_io_clock_domain_en_o,
   input wire converter_clock_domain_en_o,
   input wire main_osc_en_o,
   input wire adc_en_o,
   input wire comp_en_o,
   input wire vref_en_o,
   input wire bod_en_o,
   input wire wdt_en_o,
   input wire input_buf_en_o,
   input wire [2:0] wake_pin_buf_en_o,
   input wire sleeping_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   wire core_w = core_clock_domain_en_o;
   wire io_w = peripheral_io_clock_domain_en_o;
   wire conv_w = converter_clock_domain_en_o;
   wire deep_w = sleeping_o && !io_w && !conv_w;
   // standby is the only sleeping state with oscillator up and converter off
   wire stby_w = sleeping_o && main_osc_en_o && !conv_w;

   sleep_gate_a: assert property (
      sleeping_o |-> !core_w && !program_memory_clock_domain_en_o)
      else $error("core clock running while asleep");
   awake_run_a: assert property (
      !sleeping_o |-> core_w && program_memory_clock_domain_en_o && io_w
      && conv_w && main_osc_en_o) else $error("clock stopped while awake");
   entry_cause_a: assert property (
      $rose(sleeping_o) |-> $past(sleep_instr_i))
      else $error("sleep entered without entry instruction");
   pdown_all_a: assert property (
      !main_osc_en_o |-> !core_w && !io_w && !conv_w)
      else $error("clock running with oscillator off");
   buf_off_a: assert property (
      deep_w |-> !input_buf_en_o) else $error("input buffers left on");
   wake_pin_a: assert property (
      deep_w |-> wake_pin_buf_en_o[2]) else $error("address pin buffer off");
   comp_off_a: assert property (
      sleeping_o && !conv_w |-> !comp_en_o) else $error("comparator left on");
   bod_keep_a: assert property (
      brownout_enable_fuse_i && sleeping_o |=> bod_en_o)
      else $error("brown-out detector dropped in sleep");
   wdt_keep_a: assert property (
      wdt_enable_i && sleeping_o |=> wdt_en_o)
      else $error("watchdog dropped in sleep");
   vref_need_a: assert property (
      (bod_en_o || adc_en_o) [*2] |-> vref_en_o)
      else $error("reference off while needed");
   vref_off_a: assert property (
      (!bod_en_o && !adc_en_o && !comp_en_o && !sleeping_o) [*2]
      |-> !vref_en_o)
      else $error("reference on while unused");
   stby_wake_a: assert property (
      stby_w && two_wire_iface_match_i && !$past(two_wire_iface_match_i)
      |-> ##6 !core_w ##1 core_w) else $error("standby wake not 6 cycles");
   idle_wake_a: assert property (
      sleeping_o && io_w && other_io_irq_i |=> core_w)
      else $error("idle not woken by interrupt");

   cover property ($rose(sleeping_o));
   cover property (stby_w && two_wire_iface_match_i);
   cover property (sleeping_o && io_w && other_io_irq_i);
endmodule // slp_ctrl_checker

bind slp_ctrl slp_ctrl_checker chk_u (.*);

/* File: sim/slp_core_model.sv */
// slp_core_model: processor core issuing the low-power entry instruction.
// assumes the bench asks by a one-cycle exec_i pulse.
`timescale 1ns/100ps
module slp_core_model (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // request and core clock
   input wire exec_i,
   input wire core_clk_en_i,
   // instruction strobe
   output reg sleep_instr_o
);
   // a gated core executes nothing, so requests while asleep are lost
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i)
         sleep_instr_o <= 1'b0;
      else
         sleep_instr_o <= exec_i && core_clk_en_i;
   end
endmodule // slp_core_model

/* File: sim/tb_top.sv */
// tb_top: self-checking bench for the sleep-mode clock controller.
// assumes slp_ctrl with a short power-down wake delay and the core model.
`timescale 1ns/100ps
`include "slp_map.vh"
module tb_top;
   localparam PD = 2;
   reg clk_i, nrst_i, xtal, fuse, wdt, sleep_req, conv_start;
   reg awvalid, wvalid, bready, arvalid, rready;
   reg [3:0] awaddr, araddr;
   reg [31:0] wdata, rd;
   reg [1:0] resp;
   reg [8:0] src;
   reg [18:0] r;
   reg [35:0] w;
   wire awready, wready, bvalid, arready, rvalid, sleep_instr;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire core, flash, io, conv, asy, mosc, tosc, adc_en, ext_conv, comp_en;
   wire vref_en, vref_rdy, bod_en, wdt_en, in_buf, sleeping;
   wire [2:0] pin_buf;
   wire [6:0] clks = {core, flash, io, conv, asy, mosc, tosc};
   integer mismatches, n_tests, i, n;

   slp_ctrl #(.PD_WAKE_CYC(PD)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sleep_instr_i(sleep_instr), .xtal_clk_option_i(xtal),
      .brownout_enable_fuse_i(fuse), .wdt_enable_i(wdt),
      .ext_irq_line_0_i(~src[3]), .ext_irq_line_1_i(~src[4]),
      .ext_irq_req_0_i(src[5]), .ext_irq_req_1_i(src[6]),
      .two_wire_iface_match_i(src[0]), .timer2_irq_i(src[2]),
      .self_program_op_rdy_i(src[7]), .adc_done_irq_i(src[8]),
      .other_io_irq_i(src[1]), .adc_conv_start_i(conv_start),
      .core_clock_domain_en_o(core), .program_memory_clock_domain_en_o(flash),
      .peripheral_io_clock_domain_en_o(io), .converter_clock_domain_en_o(conv),
      .async_timer_clock_domain_en_o(asy), .main_osc_en_o(mosc),
      .timer_osc_en_o(tosc), .adc_en_o(adc_en), .adc_ext_conv_o(ext_conv),
      .comp_en_o(comp_en), .vref_en_o(vref_en), .vref_ready_o(vref_rdy),
      .bod_en_o(bod_en), .wdt_en_o(wdt_en), .input_buf_en_o(in_buf),
      .wake_pin_buf_en_o(pin_buf), .sleeping_o(sleeping));

   slp_core_model core_m (.clk_i(clk_i), .nrst_i(nrst_i), .exec_i(sleep_req),
      .core_clk_en_i(core), .sleep_instr_o(sleep_instr));

   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            mismatches = mismatches + 1;
         end
      end
   endtask

   task axi(input wr, input [3:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         awaddr <= a;
         araddr <= a;
         wdata <= d;
         awvalid <= wr;
         wvalid <= wr;
         bready <= wr;
         arvalid <= !wr;
         rready <= !wr;
         @(negedge clk_i);
         while ((wr ? awready : arready) !== 1'b1) @(negedge clk_i);
         @(posedge clk_i);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         arvalid <= 1'b0;
         @(negedge clk_i);
         while ((wr ? bvalid : rvalid) !== 1'b1) @(negedge clk_i);
         resp = wr ? bresp : rresp;
         rd = rdata;
         @(posedge clk_i);
         bready <= 1'b0;
         rready <= 1'b0;
      end
   endtask

   // leaves time for register-to-enable pipelining before looking
   task settle;
      begin
         repeat (3) @(posedge clk_i);
         @(negedge clk_i);
      end
   endtask

   task do_sleep;
      begin
         @(posedge clk_i);
         sleep_req <= 1'b1;
         @(posedge clk_i);
         sleep_req <= 1'b0;
         settle;
      end
   endtask

   // one-cycle pulse on the given sources; n counts cycles to core clock
   task wake(input [8:0] v);
      begin
         @(posedge clk_i);
         src <= v;
         @(posedge clk_i);
         src <= 9'h000;
         n = 1;
         @(negedge clk_i);
         while (core !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n = n + 1;
         end
      end
   endtask

   // {mode, async select, clocks core..tosc, wake latency}
   function [18:0] row(input integer k);
      case (k)
         0: row = {`SLP_MODE_IDLE, 1'b0, 7'h1a, 8'h01};
         1: row = {`SLP_MODE_NOISE, 1'b1, 7'h0f, 8'h01};
         2: row = {`SLP_MODE_PSAVE, 1'b1, 7'h05, 8'(PD + 1)};
         3: row = {`SLP_MODE_PDOWN, 1'b0, 7'h00, 8'(PD + 1)};
         default: row = {`SLP_MODE_STBY, 1'b0, 7'h02, 8'h07};
      endcase
   endfunction

   // {control, ignored sources, waking source, latency}
   function [35:0] wrow(input integer k);
      case (k)
         0: wrow = {9'h092, 9'h1f6, 9'h008, 9'(PD + 1)};
         1: wrow = {9'h010, 9'h004, 9'h002, 9'h001};
         default: wrow = {9'h011, 9'h026, 9'h080, 9'h001};
      endcase
   endfunction

   task end_of_test;
      begin
         $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // the whole run needs about 1200 cycles; allow 20000, over sixteen times that
   initial begin
      #(50 * 20000);
      mismatches = mismatches + 1;
      end_of_test;
   end

   initial begin
      {mismatches, n_tests, nrst_i, fuse, wdt, sleep_req, conv_start} = 0;
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
      src = 9'h000;
      xtal = 1'b1;
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(negedge clk_i);
      chk(32'({clks, in_buf, pin_buf, sleeping}), 32'h0000_0ffe);
      axi(1'b0, `SLP_CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      axi(1'b0, 4'h8, 32'h0);
      chk({rd[29:0], resp}, {30'h0, `SLP_RESP_ERR});
      chk(32'(vref_en), 32'h0);
      axi(1'b0, `SLP_STAT_OFS, 32'h0);
      chk(rd, 32'h0000_1fc1);
      $display("test reset and map done");

      axi(1'b1, `SLP_CTRL_OFS, 32'h0000_0010);
      chk(32'(resp), 32'(`SLP_RESP_OK));
      settle;
      @(posedge clk_i);
      conv_start <= 1'b1;
      @(posedge clk_i);
      conv_start <= 1'b0;
      axi(1'b1, `SLP_CTRL_OFS, 32'h0);
      axi(1'b1, `SLP_CTRL_OFS, 32'h0000_0010);
      settle;
      chk(32'({ext_conv, vref_en, vref_rdy}), 32'h6);
      @(posedge clk_i);
      conv_start <= 1'b1;
      @(posedge clk_i);
      conv_start <= 1'b0;
      settle;
      chk(32'(ext_conv), 32'h0);
      repeat (900) @(posedge clk_i);
      fuse <= 1'b1;
      wdt <= 1'b1;
      settle;
      chk(32'(vref_rdy), 32'h1);
      $display("test converter and reference done");

      for (i = 0; i < 5; i = i + 1) begin
         r = row(i);
         axi(1'b1, `SLP_CTRL_OFS, 32'h0000_01b0 | {28'h0, r[15], r[18:16]});
         do_sleep;
         chk(32'(clks[6:3]), 32'(r[14:11]));
         chk(32'(clks[2:0]), 32'(r[10:8]));
         chk(32'(sleeping), 32'h1);
         chk(32'(in_buf), 32'(r[12] | r[11]));
         chk(32'(comp_en), 32'(r[11]));
         chk(32'({adc_en, bod_en}), 32'h3);
         chk(32'({wdt_en, pin_buf[2]}), 32'h3);
         wake(9'h001);
         chk(n, 32'(r[7:0]));
         chk(32'(vref_rdy), 32'h1);
      end
      $display("test mode table done");

      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk_i);
         xtal <= (i != 3);
         axi(1'b1, `SLP_CTRL_OFS, (i == 3) ? 32'h6 : 32'(i + 4 + (i == 2)));
         do_sleep;
         chk(32'({sleeping, core}), 32'h1);
      end
      @(posedge clk_i);
      xtal <= 1'b1;
      $display("test unsupported codes done");

      for (i = 0; i < 3; i = i + 1) begin
         w = wrow(i);
         axi(1'b1, `SLP_CTRL_OFS, {23'h0, w[35:27]});
         do_sleep;
         if (i == 0)
            chk(32'(pin_buf), 32'h5);
         wake(w[26:18]);
         chk(n, 40);
         wake(w[17:9]);
         chk(n, 32'(w[8:0]));
      end
      $display("test wake sources done");
      end_of_test;
   end
endmodule // tb_top
